/* masec_top.sv */
/*
 Memory access decode and program security logic.
 Assumes registers are reached at their printed special function or
 external addresses by the core's write strobes and read back on the rdata outputs, synchronous inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module masec_top #(
  parameter int PREBOOT_LEN = masec_pkg::PREBOOT_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Core special function register access
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_flash_ctrl_rdata,
  // External space register access
  input wire logic i_xsfr_wr,
  input wire logic [15:0] i_xaddr_wr,
  input wire logic [7:0] i_xsfr_wdata,
  output logic [7:0] o_sec_fuse_rdata,
  // Fuse and strap levels
  input wire logic i_boot_strap_level,
  input wire logic i_lock_fuse_one,
  input wire logic i_lock_fuse_zero,
  // Internal memory access
  input wire logic [7:0] i_iram_addr,
  input wire logic i_iram_indirect,
  input wire logic [1:0] i_bank_sel,
  input wire logic [2:0] i_reg_num,
  input wire logic [6:0] i_bit_addr,
  output logic [7:0] o_iram_index,
  output logic o_iram_upper_ram,
  output logic o_iram_sfr,
  output logic [7:0] o_bit_byte,
  output logic [2:0] o_bit_pos,
  // External move address
  input wire logic i_xmove_ri,
  input wire logic [7:0] i_ri_value,
  input wire logic [15:0] i_primary_data_pointer,
  input wire logic [15:0] i_alternate_data_pointer,
  output logic [15:0] o_xaddr,
  output logic [15:0] o_active_pointer,
  output logic o_pointer_select,
  output logic o_xr_ram,
  output logic o_xr_usb,
  output logic o_xr_card,
  output logic o_xr_periph,
  // Flash requests
  input wire logic i_page_erase_req,
  input wire logic i_page_write_req,
  input wire logic i_from_debug,
  input wire logic [6:0] i_page,
  input wire logic i_global_erase,
  input wire logic i_debug_read_req,
  input wire logic i_debug_op_req,
  output logic o_page_erase_ok,
  output logic o_page_write_ok,
  output logic o_debug_read_ok,
  output logic o_debug_op_ok,
  output logic o_global_erase_ok,
  output logic o_xram_clear,
  // Status
  output logic o_debug_enabled,
  output logic o_preboot,
  output logic o_protect,
  output logic o_fuse_program_enable
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [5:0] cnt;
    logic preboot;
    logic protect;
    logic fuse_prog;
    logic ptr_sel;
    logic [7:0] flash_rd;
    logic [7:0] fuse_rd;
    logic xclr;
  } masec_state_t;

  masec_state_t st, next_st;

  function automatic masec_pkg::masec_xregion_t xregion(
    input logic [15:0] a);
    masec_pkg::masec_xregion_t r;
    r = masec_pkg::MASEC_XR_NONE;
    if (a <= masec_pkg::XRAM_END) begin
      r = masec_pkg::MASEC_XR_RAM;
    end else if (a >= masec_pkg::USB_BASE && a <= masec_pkg::USB_END) begin
      r = masec_pkg::MASEC_XR_USB;
    end else if (a >= masec_pkg::CARD_BASE && a <= masec_pkg::CARD_END) begin
      r = masec_pkg::MASEC_XR_CARD;
    end else if (a >= masec_pkg::PERIPH_BASE) begin
      r = masec_pkg::MASEC_XR_PERIPH;
    end
    return r;
  endfunction

  localparam logic [5:0] PB_LAST = 6'(PREBOOT_LEN - 1);

  // ==========================================================
  // Register updates
  always_comb begin
    next_st = st;
    if (st.preboot) begin
      if (st.cnt == PB_LAST) begin
        next_st.preboot = 1'b0;
      end else begin
        next_st.cnt = st.cnt + 6'd1;
      end
    end
    if (i_sfr_wr && i_sfr_addr == masec_pkg::FLASH_CTRL_ADDR &&
        i_sfr_wdata[masec_pkg::PROTECT_BIT]) begin
      next_st.protect = 1'b1; // set only; cleared by reset
    end
    if (i_sfr_wr && i_sfr_addr == masec_pkg::POINTER_SEL_ADDR) begin
      next_st.ptr_sel = i_sfr_wdata[0];
    end
    if (i_xsfr_wr && i_xaddr_wr == masec_pkg::SEC_FUSE_ADDR) begin
      next_st.fuse_prog = i_xsfr_wdata[masec_pkg::FUSE_PROG_EN_BIT];
    end
    next_st.flash_rd = masec_pkg::RESET_BYTE;
    next_st.flash_rd[masec_pkg::PROTECT_BIT] = next_st.protect;
    next_st.flash_rd[masec_pkg::EARLY_BOOT_BIT] = next_st.preboot;
    next_st.fuse_rd = masec_pkg::RESET_BYTE;
    next_st.fuse_rd[masec_pkg::FUSE_PROG_EN_BIT] = next_st.fuse_prog;
    next_st.fuse_rd[masec_pkg::BOOT_STRAP_BIT] = i_boot_strap_level;
    next_st.fuse_rd[masec_pkg::LOCK_ONE_BIT] = i_lock_fuse_one;
    next_st.fuse_rd[masec_pkg::LOCK_ZERO_BIT] = i_lock_fuse_zero;
    // Global erase wipes external RAM whatever the protect bit holds; fuse one or pre-boot blocks it
    next_st.xclr = i_global_erase && o_global_erase_ok;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st <= '0;
      st.preboot <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Internal memory decode
  always_comb begin
    o_iram_sfr = !i_iram_indirect && i_iram_addr >= masec_pkg::UPPER_HALF_BASE;
    o_iram_upper_ram = i_iram_indirect &&
      i_iram_addr >= masec_pkg::UPPER_HALF_BASE;
    o_iram_index = i_iram_addr;
    if (!i_iram_indirect && i_iram_addr <= masec_pkg::BANK_AREA_END &&
        i_iram_addr[7:5] == 3'b000) begin
      o_iram_index = i_iram_addr;
    end
    o_bit_byte = masec_pkg::BIT_AREA_BASE + {4'h0, i_bit_addr[6:3]};
    o_bit_pos = i_bit_addr[2:0];
  end

  // Register bank address of R0-R7 by i_reg_num/for Ri moves, from PROGRAM_STATUS_WORD bank bits
  logic [7:0] bank_reg_addr;
  assign bank_reg_addr = {3'b000, i_bank_sel, i_reg_num};

  // ==========================================================
  // External address and pointer select
  masec_pkg::masec_xregion_t xr;
  assign o_pointer_select = st.ptr_sel;
  assign o_active_pointer = st.ptr_sel ? i_alternate_data_pointer :
                            i_primary_data_pointer;
  assign o_xaddr = i_xmove_ri ? {8'h00, i_ri_value} : o_active_pointer;
  assign xr = xregion(o_xaddr);
  assign o_xr_ram = xr == masec_pkg::MASEC_XR_RAM;
  assign o_xr_usb = xr == masec_pkg::MASEC_XR_USB;
  assign o_xr_card = xr == masec_pkg::MASEC_XR_CARD;
  assign o_xr_periph = xr == masec_pkg::MASEC_XR_PERIPH;

  // ==========================================================
  // Security gating
  logic page0;
  logic dbg_on;
  assign page0 = i_page == 7'd0;
  // Fuse input is combinational so it acts even while reset holds
  assign dbg_on = !st.preboot && !i_lock_fuse_one;
  assign o_debug_enabled = dbg_on;
  assign o_debug_op_ok = i_debug_op_req && dbg_on && !st.protect;
  assign o_debug_read_ok = i_debug_read_req && dbg_on && !st.protect;
  assign o_global_erase_ok = dbg_on;
  assign o_page_erase_ok = i_page_erase_req &&
    !(page0 && (st.protect || (i_lock_fuse_one && !i_from_debug))) &&
    !(i_from_debug && (!dbg_on || st.protect));
  assign o_page_write_ok = i_page_write_req &&
    !(page0 && (st.protect || (i_lock_fuse_one && !i_from_debug))) &&
    !(i_from_debug && (!dbg_on || st.protect));
  assign o_xram_clear = st.xclr;
  assign o_preboot = st.preboot;
  assign o_protect = st.protect;
  assign o_fuse_program_enable = st.fuse_prog;
  assign o_flash_ctrl_rdata = st.flash_rd;
  assign o_sec_fuse_rdata = st.fuse_rd;

  // ==========================================================
  // Checks
  sequence s_reset_rel;
    !$past(i_rst_b) && i_rst_b;
  endsequence

  a_preboot_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    s_reset_rel |-> o_preboot [*8]) else $error("preboot too short");
  a_preboot_end: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $fell(o_preboot) |-> !i_lock_fuse_one |-> o_debug_enabled)
    else $error("debug not enabled");
  a_protect_sticky: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) o_protect |=> o_protect)
    else $error("protect cleared");
  a_protect_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_sfr_wr && i_sfr_addr == masec_pkg::FLASH_CTRL_ADDR &&
    i_sfr_wdata[masec_pkg::PROTECT_BIT] |=> o_protect)
    else $error("protect not set");
  a_dbg_read_blk: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) o_protect |-> !o_debug_read_ok)
    else $error("read leaked");
  a_fuse_one_blk: assert property (@(posedge i_core_clk)
    i_lock_fuse_one |-> !o_debug_enabled && !o_debug_op_ok)
    else $error("fuse lock leaked");
  a_page0_guard: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_protect && i_page == 7'd0 |-> !o_page_erase_ok && !o_page_write_ok)
    else $error("page zero open");
  a_ptr_select: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !i_xmove_ri |-> o_xaddr == (o_pointer_select ? i_alternate_data_pointer
    : i_primary_data_pointer)) else $error("wrong pointer");
  a_xram_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_global_erase && o_global_erase_ok |=> o_xram_clear)
    else $error("xram not cleared");
  a_ri_addr: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_xmove_ri |-> o_xaddr[15:8] == 8'h00 && o_xr_ram)
    else $error("ri address wrong");
endmodule
`default_nettype wire

/* masec_pkg.sv */
/*
 Package for the memory access decode and program security block.
 Holds address map constants, register layouts, reset values and timing.
 Assumes the core and debug port share the core clock and chip reset.
*/
package masec_pkg;
  // ==========================================================
  // Security fuse register
  localparam logic [15:0] SEC_FUSE_ADDR = 16'hffd7;
  localparam int FUSE_PROG_EN_BIT = 7;
  localparam int BOOT_STRAP_BIT = 5;
  localparam int LOCK_ONE_BIT = 1;
  localparam int LOCK_ZERO_BIT = 0;
  // ==========================================================
  // Flash control and pointer select registers
  localparam logic [7:0] FLASH_CTRL_ADDR = 8'hb2;
  localparam int PROTECT_BIT = 6;
  localparam int EARLY_BOOT_BIT = 7;
  localparam logic [7:0] POINTER_SEL_ADDR = 8'h92;
  // ==========================================================
  // Internal data memory
  localparam logic [7:0] UPPER_HALF_BASE = 8'h80;
  localparam logic [7:0] BANK_AREA_END = 8'h1f;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_AREA_END = 8'h2f;
  // ==========================================================
  // External data space
  localparam logic [15:0] XRAM_END = 16'h07ff;
  localparam logic [15:0] USB_BASE = 16'hfc00;
  localparam logic [15:0] USB_END = 16'hfdff;
  localparam logic [15:0] CARD_BASE = 16'hfe00;
  localparam logic [15:0] CARD_END = 16'hff7f;
  localparam logic [15:0] PERIPH_BASE = 16'hff80;
  // ==========================================================
  // Timing and reset values
  localparam int PREBOOT_CYCLES = 32;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [1:0] {
    MASEC_DIRECT,
    MASEC_INDIRECT,
    MASEC_BIT
  } masec_mode_t;

  typedef enum logic [2:0] {
    MASEC_XR_NONE,
    MASEC_XR_RAM,
    MASEC_XR_USB,
    MASEC_XR_CARD,
    MASEC_XR_PERIPH
  } masec_xregion_t;
endpackage

/* masec_far_model.sv */
/*
 Far-side model: the board around the security strap pin.
 Assumes the bench drives the pin only during the fuse register check.
*/
`timescale 1ns/1ps
`default_nettype none
module masec_far_model (
  // Board drive
  input wire logic i_drive_en,
  input wire logic i_drive_val,
  // Pin level seen by the block
  output logic o_strap_level
);
  // ==========================================================
  // Pull-down wins whenever nobody drives the pin
  assign o_strap_level = i_drive_en ? i_drive_val : 1'b0;
endmodule
`default_nettype wire

/* tb_top.sv */
/*
 Self-checking bench for the memory decode and security block.
 Assumes a shortened pre-boot count; expectations derive from it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PB = 8;
  logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_sfr_wr = 1'b0;
  logic i_xsfr_wr = 1'b0, i_xmove_ri = 1'b0, i_iram_indirect = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
  logic [7:0] i_xsfr_wdata = 8'h00, i_iram_addr = 8'h00;
  logic [7:0] i_ri_value = 8'h00;
  logic [15:0] i_xaddr_wr = 16'h0000, i_primary_data_pointer = 16'h0000;
  logic [15:0] i_alternate_data_pointer = 16'h0000;
  logic i_lock_fuse_one = 1'b0, i_lock_fuse_zero = 1'b0;
  logic strap_en = 1'b0, strap_val = 1'b0, i_boot_strap_level;
  logic [1:0] i_bank_sel = 2'b00;
  logic [2:0] i_reg_num = 3'b000, o_bit_pos;
  logic [6:0] i_bit_addr = 7'h00, i_page = 7'h00;
  logic i_page_erase_req = 1'b0, i_page_write_req = 1'b0;
  logic i_from_debug = 1'b0, i_global_erase = 1'b0;
  logic i_debug_read_req = 1'b0, i_debug_op_req = 1'b0;
  logic [7:0] o_flash_ctrl_rdata, o_sec_fuse_rdata, o_iram_index, o_bit_byte;
  logic [15:0] o_xaddr, o_active_pointer;
  logic o_iram_upper_ram, o_iram_sfr, o_pointer_select;
  logic o_xr_ram, o_xr_usb, o_xr_card, o_xr_periph, o_xram_clear;
  logic o_page_erase_ok, o_page_write_ok, o_debug_read_ok, o_debug_op_ok;
  logic o_global_erase_ok, o_debug_enabled, o_preboot, o_protect;
  logic o_fuse_program_enable;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  typedef struct packed {
    logic [7:0] a;
    logic ind;
    logic [6:0] b;
    logic [15:0] p;
    logic [1:0] su;
    logic [10:0] bb;
    logic [3:0] rg;
  } masec_row_t;
  // Address, mode, bit address, pointer -> sfr/upper, bit byte+pos, region
  localparam masec_row_t ROWS [10] = '{
    '{8'h00, 1'b0, 7'h00, 16'h0000, 2'b00, 11'h100, 4'b1000},
    '{8'h7f, 1'b1, 7'h7f, 16'h07ff, 2'b00, 11'h17f, 4'b1000},
    '{8'h80, 1'b0, 7'h08, 16'h0800, 2'b10, 11'h108, 4'b0000},
    '{8'h80, 1'b1, 7'h0f, 16'hfc00, 2'b01, 11'h10f, 4'b0100},
    '{8'hff, 1'b1, 7'h10, 16'hfdff, 2'b01, 11'h110, 4'b0100},
    '{8'hff, 1'b0, 7'h3a, 16'hfe00, 2'b10, 11'h13a, 4'b0010},
    '{8'h7f, 1'b0, 7'h00, 16'hff7f, 2'b00, 11'h100, 4'b0010},
    '{8'h7f, 1'b1, 7'h00, 16'hff80, 2'b00, 11'h100, 4'b0001},
    '{8'h20, 1'b0, 7'h00, 16'hffff, 2'b00, 11'h100, 4'b0001},
    '{8'h1f, 1'b1, 7'h00, 16'hfbff, 2'b00, 11'h100, 4'b0000}};

  masec_far_model far (.i_drive_en(strap_en), .i_drive_val(strap_val),
    .o_strap_level(i_boot_strap_level));
  masec_top #(.PREBOOT_LEN(PB)) DUT (.i_core_clk, .i_rst_b, .i_sfr_wr,
    .i_sfr_addr, .i_sfr_wdata, .o_flash_ctrl_rdata, .i_xsfr_wr, .i_xaddr_wr,
    .i_xsfr_wdata, .o_sec_fuse_rdata, .i_boot_strap_level, .i_lock_fuse_one,
    .i_lock_fuse_zero, .i_iram_addr, .i_iram_indirect, .i_bank_sel,
    .i_reg_num, .i_bit_addr, .o_iram_index, .o_iram_upper_ram, .o_iram_sfr,
    .o_bit_byte, .o_bit_pos, .i_xmove_ri, .i_ri_value,
    .i_primary_data_pointer, .i_alternate_data_pointer, .o_xaddr,
    .o_active_pointer, .o_pointer_select, .o_xr_ram, .o_xr_usb, .o_xr_card,
    .o_xr_periph, .i_page_erase_req, .i_page_write_req, .i_from_debug,
    .i_page, .i_global_erase, .i_debug_read_req, .i_debug_op_req,
    .o_page_erase_ok, .o_page_write_ok, .o_debug_read_ok, .o_debug_op_ok,
    .o_global_erase_ok, .o_xram_clear, .o_debug_enabled, .o_preboot,
    .o_protect, .o_fuse_program_enable);

  // ==========================================================
  // Clock, timeout and shared tasks
  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_wr = 1'b1;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    step(1);
    i_sfr_wr = 1'b0;
  endtask
  task automatic xwr(input logic [15:0] a, input logic [7:0] d);
    i_xsfr_wr = 1'b1;
    i_xaddr_wr = a;
    i_xsfr_wdata = d;
    step(1);
    i_xsfr_wr = 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    step(4);
    cmp({o_preboot, o_protect, o_pointer_select}, 16'h4, "reset");
    i_rst_b = 1'b1;
    i_debug_op_req = 1'b1;
    i_debug_read_req = 1'b1;
    step(PB - 1);
    cmp({o_debug_op_ok, o_debug_enabled}, 16'h0, "preboot gate");
    cmp({8'h00, o_flash_ctrl_rdata}, 16'h0080, "early flag");
    step(2);
    cmp({o_preboot, o_debug_enabled}, 16'h1, "preboot end");
    cmp({o_debug_op_ok, o_debug_read_ok}, 16'h3, "debug open");
    foreach (ROWS[k]) begin
      i_iram_addr = ROWS[k].a;
      i_iram_indirect = ROWS[k].ind;
      i_bit_addr = ROWS[k].b;
      i_primary_data_pointer = ROWS[k].p;
      #1;
      cmp({8'h00, o_iram_index}, {8'h00, ROWS[k].a}, "index");
      cmp({o_iram_sfr, o_iram_upper_ram}, ROWS[k].su, "upper");
      cmp({o_bit_byte, o_bit_pos}, ROWS[k].bb, "bit map");
      cmp(o_xaddr, ROWS[k].p, "primary_data_pointer addr");
      cmp({o_xr_ram, o_xr_usb, o_xr_card, o_xr_periph}, ROWS[k].rg,
          "region");
      step(1);
    end
    // Pointer select: only bit zero counts
    i_alternate_data_pointer = 16'h5a5a;
    sfr_wr(masec_pkg::POINTER_SEL_ADDR, 8'hfe);
    cmp(o_active_pointer, 16'hfbff, "ptr kept");
    step(1);
    sfr_wr(masec_pkg::POINTER_SEL_ADDR, 8'h01);
    cmp(o_xaddr, 16'h5a5a, "alt ptr");
    cmp({15'h0, o_pointer_select}, 16'h1, "ptr sel");
    i_xmove_ri = 1'b1;
    i_ri_value = 8'hc3;
    #1;
    cmp(o_xaddr, 16'h00c3, "ri addr");
    // Fuse register and strap pin
    strap_en = 1'b1;
    strap_val = 1'b1;
    i_lock_fuse_zero = 1'b1;
    xwr(masec_pkg::SEC_FUSE_ADDR, 8'h80);
    step(1);
    cmp({8'h00, o_sec_fuse_rdata}, 16'h00a1, "fuse reg");
    strap_en = 1'b0;
    i_lock_fuse_zero = 1'b0;
    xwr(16'hffd6, 8'h00);
    step(1);
    cmp({o_fuse_program_enable, o_sec_fuse_rdata}, 16'h0180,
        "pull-down");
    xwr(masec_pkg::SEC_FUSE_ADDR, 8'h00);
    step(1);
    cmp({15'h0, o_fuse_program_enable}, 16'h0, "fuse normal");
    // Protect bit: set only, gates page zero and debug
    i_page_erase_req = 1'b1;
    i_page_write_req = 1'b1;
    #1;
    cmp({o_page_erase_ok, o_page_write_ok}, 16'h3, "page0 open");
    sfr_wr(masec_pkg::FLASH_CTRL_ADDR, 8'h40);
    step(1);
    cmp({8'h00, o_flash_ctrl_rdata}, 16'h0040, "protect set");
    sfr_wr(masec_pkg::FLASH_CTRL_ADDR, 8'h00);
    cmp({o_protect, o_page_erase_ok, o_page_write_ok}, 16'h4,
        "page0 core");
    i_from_debug = 1'b1;
    #1;
    cmp({o_page_erase_ok, o_page_write_ok}, 16'h0, "page0 debug");
    cmp({o_debug_read_ok, o_debug_op_ok}, 16'h0, "debug shut");
    i_page = 7'h01;
    i_global_erase = 1'b1;
    #1;
    cmp({o_page_erase_ok, o_global_erase_ok}, 16'h1, "erase ok");
    step(1);
    i_global_erase = 1'b0;
    cmp({o_xram_clear, o_protect}, 16'h3, "xram clear");
    step(1);
    cmp({15'h0, o_xram_clear}, 16'h0, "clear pulse");
    // Full reset after the erase, now with fuse one blown
    i_lock_fuse_one = 1'b1;
    i_rst_b = 1'b0;
    step(1);
    cmp({o_protect, o_debug_enabled}, 16'h0, "unlock");
    i_rst_b = 1'b1;
    step(PB + 2);
    i_from_debug = 1'b0;
    i_page = 7'h00;
    #1;
    cmp({o_debug_enabled, o_debug_op_ok, o_global_erase_ok}, 16'h0,
        "fuse lock");
    cmp({o_page_erase_ok, o_page_write_ok}, 16'h0, "core page0");
    cmp({8'h00, o_sec_fuse_rdata}, 16'h0002, "fuse one bit");
    print_verdict();
  end
endmodule
`default_nettype wire
